/* logic/ris_pin_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module ris_pin_filter #(
  parameter bit IDLE_LEVEL = 1'b1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic pin,
  output logic level
);
  import ris_pkg::*;

  logic stage1;
  logic stage2;
  logic stage3;

  // The first stage may be metastable, so only the second stage reads it.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stage1 <= IDLE_LEVEL;
      stage2 <= IDLE_LEVEL;
      stage3 <= IDLE_LEVEL;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      level <= IDLE_LEVEL;
    end else if (stage2 == stage3) begin
      level <= stage2;
    end
  end

endmodule : ris_pin_filter
`default_nettype wire

/* logic/ris_pkg.sv */
`default_nettype none
package ris_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  // One instruction cycle equals one clk_sys period in this build.
  localparam int CLK_NS = 10;
  localparam int TCYC_NS = 10;
  localparam int POR_DELAY_TCYC = 4064;
  // A least time, so the division rounds up.
  localparam int POR_CYCLES = (POR_DELAY_TCYC * TCYC_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [2:0] ADDR_TCTRL8 = 3'h0;
  localparam logic [2:0] ADDR_TCTRL16 = 3'h1;
  localparam logic [2:0] ADDR_TSTAT16 = 3'h2;
  localparam logic [2:0] ADDR_TASSOC = 3'h3;
  localparam logic [2:0] ADDR_MISC_EN = 3'h4;
  localparam logic [2:0] ADDR_CORE_STAT = 3'h5;

  localparam int BIT_T8_REQ = 7;
  localparam int BIT_T8_MASK = 6;
  localparam int BIT_T16_LO = 5;
  localparam int T16_SRC = 3;
  localparam int BIT_SER_EN = 0;
  localparam int BIT_KBD_EN = 1;
  localparam int BIT_ST_MASK = 0;
  localparam int BIT_ST_PIN = 1;
  localparam int BIT_ST_EDGE = 2;
  localparam int BIT_ST_WAIT = 3;
  localparam int BIT_ST_STOP = 4;

  localparam logic [7:0] TIMER_COUNT_ONE = 8'h01;
  localparam logic [7:0] TIMER_COUNT_ZERO = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    VEC_RESET, VEC_SWI, VEC_EXT, VEC_TIMER, VEC_TIMER_WAIT, VEC_T16, VEC_SERIAL, VEC_KBD
  } ris_vec_type;

  typedef struct packed {
    logic boundary;
    logic software_interrupt_instr;
    logic wait_enter;
    logic stop_enter;
    logic mask_wr;
    logic mask_val;
  } ris_cmd_type;

  typedef struct packed {
    logic core_reset;
    logic take;
    ris_vec_type vector;
    logic mask;
    logic wait_latch;
    logic stop_latch;
    logic pin_level;
  } ris_rsp_type;

endpackage : ris_pkg
`default_nettype wire

/* logic/ris_sequencer.sv */
// How it works
// R1: Power-on holds reset for 4064 cycles.
// R2: Reset pin still low extends reset.
// R3: Driver holds reset pin low long enough.
// R4: Reset clears requests and enable bits.
// R5: Reset sets the global mask bit.
// R6: Reset clears directions, stack, selects reset vector.
// R7: Reset clears stop, wait, edge latches.
// R8: Hardware sources maskable; software interrupt never.
// R9: Disabled enable blocks request, flag still sets.
// R10: Flag clears by status read, then access.
// R11: Requests wait for an instruction boundary.
// R12: Taking an interrupt sets mask, picks vector.
// R13: External request beats internal; internal stays.
// R14: Request pin level readable regardless of mask.
// R15: External request on low level or edge.
// R16: Build option selects edge-only sensing.
// R17: Pulsed sources space pulses past handler.
// R18: Pin still low retriggers after return.
// R19: Timer flag sets on one-to-zero; software clears.
// R20: Timer interrupts only with both masks clear.
// R21: Timer waking wait uses timer-wait vector.
// R22: Three wide-timer flags, own enables, one vector.
// R23: Pins pass synchronisers before edge detection.
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ris_sequencer #(
  parameter int POR_COUNT = ris_pkg::POR_CYCLES,
  parameter bit EDGE_ONLY = 1'b0
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic reset_pin_n,
  input wire logic irq_pin_n,
  input wire ris_pkg::ris_cmd_type cpu_cmd,
  input wire logic [7:0] timer_count,
  input wire logic [ris_pkg::T16_SRC-1:0] t16_event,
  input wire logic serial_flag,
  input wire logic kbd_flag,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output ris_pkg::ris_rsp_type cpu_rsp
);
  import ris_pkg::*;

  localparam int CW = $clog2(POR_COUNT + 1);
  localparam logic [CW-1:0] POR_LAST = CW'(POR_COUNT - 1);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  localparam logic [CW-1:0] CNT_ZERO = CW'(0);

  typedef enum logic [1:0] {ST_POR, ST_HOLD, ST_RUN} ris_state_type;

  function automatic logic hit(input logic [2:0] addr, input logic [2:0] target);
    hit = (addr == target);
  endfunction : hit

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic reset_level;
  logic irq_level;

  ris_pin_filter #(.IDLE_LEVEL(1'b1)) u_reset_filter ( // see R23
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pin(reset_pin_n),
    .level(reset_level)
  );

  ris_pin_filter #(.IDLE_LEVEL(1'b1)) u_irq_filter ( // see R23
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pin(irq_pin_n),
    .level(irq_level)
  );

  // ==========================================================================
  // Reset sequencing
  // ==========================================================================
  ris_state_type state;
  ris_state_type next_state;
  logic [CW-1:0] por_count;
  logic core_reset;

  always_comb begin
    next_state = state;
    case (state)
      ST_POR: begin
        if (por_count == POR_LAST) begin // see R1
          next_state = reset_level ? ST_RUN : ST_HOLD; // see R2
        end
      end
      ST_HOLD: begin
        if (reset_level) begin // see R2
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!reset_level) begin
          next_state = ST_HOLD;
        end
      end
      default: next_state = ST_POR;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= ST_POR;
    end else begin
      state <= next_state;
    end
  end

  // The count only runs once per power-up; the pin alone cannot restart it.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      por_count <= CNT_ZERO;
    end else if (state == ST_POR) begin
      por_count <= por_count + CNT_ONE; // see R1
    end
  end

  // The enable, flag, latch, mask and vector processes return to their reset values while this is high.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      core_reset <= 1'b1;
    end else begin
      core_reset <= (next_state != ST_RUN);
    end
  end

  // ==========================================================================
  // Registers written by software
  // ==========================================================================
  logic t8_mask;
  logic [T16_SRC-1:0] t16_en;
  logic ser_en;
  logic kbd_en;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      t8_mask <= 1'b1;
      t16_en <= '0;
      ser_en <= 1'b0;
      kbd_en <= 1'b0;
    end else if (core_reset) begin
      t8_mask <= 1'b1; // see R4
      t16_en <= '0; // see R4
      ser_en <= 1'b0; // see R4
      kbd_en <= 1'b0; // see R4
    end else if (reg_wr) begin
      if (hit(reg_addr, ADDR_TCTRL8)) begin
        t8_mask <= reg_wdata[BIT_T8_MASK];
      end
      if (hit(reg_addr, ADDR_TCTRL16)) begin
        t16_en <= reg_wdata[BIT_T16_LO +: T16_SRC]; // see R22
      end
      if (hit(reg_addr, ADDR_MISC_EN)) begin
        ser_en <= reg_wdata[BIT_SER_EN];
        kbd_en <= reg_wdata[BIT_KBD_EN];
      end
    end
  end

  // ==========================================================================
  // Narrow timer request
  // ==========================================================================
  logic [7:0] last_count;
  logic t8_flag;
  logic t8_zero;

  assign t8_zero = (last_count == TIMER_COUNT_ONE) && (timer_count == TIMER_COUNT_ZERO);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      last_count <= TIMER_COUNT_ZERO;
    end else begin
      last_count <= timer_count;
    end
  end

  // Writing a one never sets the flag; only the timer does. A zero arriving
  // with the event loses, so no expiry is dropped.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      t8_flag <= 1'b0;
    end else if (core_reset) begin
      t8_flag <= 1'b0; // see R4
    end else if (t8_zero) begin
      t8_flag <= 1'b1; // see R19, R9
    end else if (reg_wr && hit(reg_addr, ADDR_TCTRL8) && !reg_wdata[BIT_T8_REQ]) begin
      t8_flag <= 1'b0; // see R19
    end
  end

  // ==========================================================================
  // Wide timer flags with two-step clear
  // ==========================================================================
  logic [T16_SRC-1:0] t16_flag;
  logic [T16_SRC-1:0] t16_armed;
  logic stat_read;
  logic assoc_access;

  assign stat_read = reg_rd && hit(reg_addr, ADDR_TSTAT16);
  assign assoc_access = (reg_rd || reg_wr) && hit(reg_addr, ADDR_TASSOC);

  for (genvar i = 0; i < T16_SRC; i++) begin : g_t16
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        t16_flag[i] <= 1'b0;
        t16_armed[i] <= 1'b0;
      end else if (core_reset) begin
        t16_flag[i] <= 1'b0; // see R4
        t16_armed[i] <= 1'b0;
      end else begin
        if (t16_event[i]) begin
          t16_flag[i] <= 1'b1; // see R22, R9
        end else if (assoc_access && t16_armed[i]) begin
          t16_flag[i] <= 1'b0; // see R10
        end
        if (stat_read) begin
          t16_armed[i] <= t16_flag[i]; // see R10
        end else if (assoc_access) begin
          t16_armed[i] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // External request
  // ==========================================================================
  logic irq_prev;
  logic edge_latch;
  logic ext_req;

  // Edge detection reads only the filtered level, never a raw stage.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_prev <= 1'b1;
    end else begin
      irq_prev <= irq_level; // see R23
    end
  end

  // A level-sensitive build keeps asking while the pin stays low, which is
  // how wire-ORed sources get served one after another.
  assign ext_req = EDGE_ONLY ? edge_latch : (edge_latch || !irq_level); // see R15, R16, R18

  // ==========================================================================
  // Arbitration
  // ==========================================================================
  logic mask;
  logic wait_latch;
  logic stop_latch;
  logic take_hw;
  logic take_swi;
  logic hw_any;
  logic t8_req;
  logic t16_req;
  logic ser_req;
  logic kbd_req;
  ris_vec_type next_vector;

  assign t8_req = t8_flag && !t8_mask; // see R20
  assign t16_req = |(t16_flag & t16_en); // see R9, R22
  assign ser_req = serial_flag && ser_en; // see R9
  assign kbd_req = kbd_flag && kbd_en; // see R9
  assign hw_any = ext_req || t8_req || t16_req || ser_req || kbd_req;

  always_comb begin
    take_hw = cpu_cmd.boundary && !mask && hw_any; // see R8, R11, R20
    take_swi = cpu_cmd.software_interrupt_instr && !take_hw; // see R8
    next_vector = VEC_SWI;
    if (take_hw) begin
      if (ext_req) begin
        next_vector = VEC_EXT; // see R13
      end else if (t8_req) begin
        next_vector = wait_latch ? VEC_TIMER_WAIT : VEC_TIMER; // see R21
      end else if (t16_req) begin
        next_vector = VEC_T16; // see R22
      end else if (ser_req) begin
        next_vector = VEC_SERIAL;
      end else begin
        next_vector = VEC_KBD;
      end
    end
  end

  // Serving the external source consumes only its edge; internal flags stay
  // set until their own handlers clear them.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      edge_latch <= 1'b0;
    end else if (core_reset) begin
      edge_latch <= 1'b0; // see R7
    end else if (irq_prev && !irq_level) begin
      edge_latch <= 1'b1; // see R15
    end else if (take_hw && next_vector == VEC_EXT) begin
      edge_latch <= 1'b0; // see R13
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mask <= 1'b1;
    end else if (core_reset) begin
      mask <= 1'b1; // see R5
    end else if (take_hw || take_swi) begin
      mask <= 1'b1; // see R12
    end else if (cpu_cmd.wait_enter) begin
      mask <= 1'b0;
    end else if (cpu_cmd.mask_wr) begin
      mask <= cpu_cmd.mask_val;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wait_latch <= 1'b0;
      stop_latch <= 1'b0;
    end else if (core_reset) begin
      wait_latch <= 1'b0; // see R7
      stop_latch <= 1'b0; // see R7
    end else if (take_hw) begin
      wait_latch <= 1'b0;
      stop_latch <= 1'b0;
    end else begin
      if (cpu_cmd.wait_enter) begin
        wait_latch <= 1'b1;
      end
      if (cpu_cmd.stop_enter) begin
        stop_latch <= 1'b1;
      end
    end
  end

  logic take;
  ris_vec_type vector;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      take <= 1'b0;
      vector <= VEC_RESET;
    end else if (core_reset) begin
      take <= 1'b0;
      vector <= VEC_RESET; // see R6
    end else begin
      take <= take_hw || take_swi; // see R12
      if (take_hw || take_swi) begin
        vector <= next_vector; // see R12
      end
    end
  end

  // ==========================================================================
  // Register read port
  // ==========================================================================
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= READ_ZERO;
    end else begin
      reg_rdata <= READ_ZERO;
      if (reg_rd) begin
        case (reg_addr)
          ADDR_TCTRL8: begin
            reg_rdata[BIT_T8_REQ] <= t8_flag;
            reg_rdata[BIT_T8_MASK] <= t8_mask;
          end
          ADDR_TCTRL16: reg_rdata[BIT_T16_LO +: T16_SRC] <= t16_en;
          ADDR_TSTAT16: reg_rdata[BIT_T16_LO +: T16_SRC] <= t16_flag;
          ADDR_MISC_EN: begin
            reg_rdata[BIT_SER_EN] <= ser_en;
            reg_rdata[BIT_KBD_EN] <= kbd_en;
          end
          ADDR_CORE_STAT: begin
            reg_rdata[BIT_ST_MASK] <= mask;
            reg_rdata[BIT_ST_PIN] <= irq_level; // see R14
            reg_rdata[BIT_ST_EDGE] <= edge_latch;
            reg_rdata[BIT_ST_WAIT] <= wait_latch;
            reg_rdata[BIT_ST_STOP] <= stop_latch;
          end
          default: reg_rdata <= READ_ZERO;
        endcase
      end
    end
  end

  // ==========================================================================
  // Answer to the CPU sequencer
  // ==========================================================================
  // core_reset tells the core to clear its direction registers and reload
  // the stack pointer; vector holds the reset entry meanwhile.
  assign cpu_rsp = '{
    core_reset: core_reset, // see R6
    take: take,
    vector: vector,
    mask: mask,
    wait_latch: wait_latch,
    stop_latch: stop_latch,
    pin_level: irq_level // see R14
  };

endmodule : ris_sequencer
`default_nettype wire

/* verif/ris_seq_props.sv */
`timescale 1ns/1ps
`default_nettype none
module ris_seq_props #(
  parameter int POR_COUNT = ris_pkg::POR_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic reset_pin_n,
  input wire logic irq_pin_n,
  input wire ris_pkg::ris_cmd_type cpu_cmd,
  input wire logic [7:0] timer_count,
  input wire logic [ris_pkg::T16_SRC-1:0] t16_event,
  input wire logic serial_flag,
  input wire logic kbd_flag,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire ris_pkg::ris_rsp_type cpu_rsp
);
  import ris_pkg::*;
  logic [15:0] por_cnt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ==========================================================================
  // Power-on count
  // ==========================================================================
  // Saturates so a long run never wraps back below the power-on figure.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      por_cnt <= 16'h0000;
    end else if (por_cnt != 16'hffff) begin
      por_cnt <= por_cnt + 16'h0001;
    end
  end
  property p_por_len;
    $fell(cpu_rsp.core_reset) |-> por_cnt >= POR_COUNT;
  endproperty
  a_por_len: assert property (p_por_len) else $error("reset left early");
  property p_pin_hold;
    (!reset_pin_n) [*6] |-> cpu_rsp.core_reset;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin reset ignored");
  property p_rst_mask;
    cpu_rsp.core_reset && $past(cpu_rsp.core_reset) |-> cpu_rsp.mask;
  endproperty
  a_rst_mask: assert property (p_rst_mask) else $error("mask clear in reset");
  property p_rst_vec;
    cpu_rsp.core_reset && $past(cpu_rsp.core_reset) |-> cpu_rsp.vector == VEC_RESET && !cpu_rsp.take;
  endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("vector wrong in reset");
  property p_rst_latch;
    cpu_rsp.core_reset && $past(cpu_rsp.core_reset) |-> !cpu_rsp.wait_latch && !cpu_rsp.stop_latch;
  endproperty
  a_rst_latch: assert property (p_rst_latch) else $error("latch set in reset");
  property p_take_bound;
    cpu_rsp.take |-> $past(cpu_cmd.boundary) || $past(cpu_cmd.software_interrupt_instr);
  endproperty
  a_take_bound: assert property (p_take_bound) else $error("take off boundary");
  property p_hw_unmasked;
    cpu_rsp.take && cpu_rsp.vector != VEC_SWI |-> $past(cpu_cmd.boundary) && !$past(cpu_rsp.mask);
  endproperty
  a_hw_unmasked: assert property (p_hw_unmasked) else $error("masked take");
  property p_take_mask;
    cpu_rsp.take |-> cpu_rsp.mask && !cpu_rsp.core_reset;
  endproperty
  a_take_mask: assert property (p_take_mask) else $error("mask not set on take");
  property p_pin_level;
    $stable(irq_pin_n) [*6] |-> cpu_rsp.pin_level == irq_pin_n;
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("pin level wrong");
  c_ext: cover property (cpu_rsp.take && cpu_rsp.vector == VEC_EXT);
  c_twait: cover property (cpu_rsp.take && cpu_rsp.vector == VEC_TIMER_WAIT);
  c_soft: cover property (cpu_rsp.take && cpu_rsp.vector == VEC_SWI);
endmodule : ris_seq_props
bind ris_sequencer ris_seq_props #(.POR_COUNT(POR_COUNT)) u_props (
  .clk_sys(clk_sys), .nrst(nrst), .reset_pin_n(reset_pin_n), .irq_pin_n(irq_pin_n),
  .cpu_cmd(cpu_cmd), .timer_count(timer_count), .t16_event(t16_event),
  .serial_flag(serial_flag), .kbd_flag(kbd_flag), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .cpu_rsp(cpu_rsp));
`default_nettype wire

/* verif/ris_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ris_src_model #(
  parameter int RST_LEN = 40,
  parameter int IRQ_LEN = 6
) (
  input wire logic clk_sys,
  input wire logic rst_go,
  input wire logic irq_go,
  input wire logic irq_hold,
  output logic reset_pin_n,
  output logic irq_pin_n
);
  int rst_cnt = 0;
  int irq_cnt = 0;
  // Whole cycles only, far beyond the minimum, so the pin filter sees it.
  always_ff @(posedge clk_sys) begin
    if (rst_go) begin
      rst_cnt <= RST_LEN;
    end else if (rst_cnt > 0) begin
      rst_cnt <= rst_cnt - 1;
    end
  end
  // The bench spaces pulses well past a whole handler, return included.
  always_ff @(posedge clk_sys) begin
    if (irq_go) begin
      irq_cnt <= IRQ_LEN;
    end else if (irq_cnt > 0) begin
      irq_cnt <= irq_cnt - 1;
    end
  end
  assign reset_pin_n = (rst_cnt == 0);
  assign irq_pin_n = !((irq_cnt > 0) || irq_hold);
endmodule : ris_src_model
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ris_pkg::*;
  typedef struct {int k; ris_vec_type v;} ris_row_type;
  localparam int POR_SIM = 16;
  localparam ris_cmd_type C_BND = '{boundary: 1'b1, default: 1'b0};
  localparam ris_cmd_type C_MW0 = '{mask_wr: 1'b1, default: 1'b0};
  localparam ris_cmd_type C_SOFT = '{software_interrupt_instr: 1'b1, default: 1'b0};
  localparam ris_cmd_type C_WAIT = '{wait_enter: 1'b1, default: 1'b0};
  localparam ris_cmd_type C_STOP = '{stop_enter: 1'b1, default: 1'b0};
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  ris_cmd_type cpu_cmd = '0;
  logic [7:0] timer_count = 8'h05;
  logic [T16_SRC-1:0] t16_event = '0;
  logic serial_flag = 1'b0;
  logic kbd_flag = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rst_go = 1'b1;
  logic irq_go = 1'b0;
  logic irq_hold = 1'b0;
  logic reset_pin_n;
  logic irq_pin_n;
  logic [7:0] reg_rdata;
  ris_rsp_type cpu_rsp;
  ris_rsp_type cpu_rsp_e;
  int err_count = 0;
  int samples_checked = 0;
  ris_row_type rows [7] = '{'{0, VEC_EXT}, '{1, VEC_TIMER}, '{2, VEC_T16}, '{3, VEC_T16},
                            '{4, VEC_T16}, '{5, VEC_SERIAL}, '{6, VEC_KBD}};
  always #5 clk_sys = ~clk_sys;
  ris_src_model u_src (.clk_sys(clk_sys), .rst_go(rst_go), .irq_go(irq_go),
    .irq_hold(irq_hold), .reset_pin_n(reset_pin_n), .irq_pin_n(irq_pin_n));
  ris_sequencer #(.POR_COUNT(POR_SIM), .EDGE_ONLY(1'b0)) dut (.clk_sys(clk_sys), .nrst(nrst),
    .reset_pin_n(reset_pin_n), .irq_pin_n(irq_pin_n), .cpu_cmd(cpu_cmd),
    .timer_count(timer_count), .t16_event(t16_event), .serial_flag(serial_flag),
    .kbd_flag(kbd_flag), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_rsp(cpu_rsp));
  // The edge-only build shares every input; it must not retake on a held pin.
  ris_sequencer #(.POR_COUNT(POR_SIM), .EDGE_ONLY(1'b1)) dut_edge (.clk_sys(clk_sys),
    .nrst(nrst), .reset_pin_n(reset_pin_n), .irq_pin_n(irq_pin_n), .cpu_cmd(cpu_cmd),
    .timer_count(timer_count), .t16_event(t16_event), .serial_flag(serial_flag),
    .kbd_flag(kbd_flag), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(), .cpu_rsp(cpu_rsp_e));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask : rd
  task automatic cmd(input ris_cmd_type c, input logic t, input ris_vec_type v);
    @(posedge clk_sys);
    cpu_cmd <= c;
    @(posedge clk_sys);
    cpu_cmd <= '0;
    #1;
    chk("take", {7'h00, cpu_rsp.take}, {7'h00, t});
    if (t) begin
      chk("vector", {5'h00, cpu_rsp.vector}, {5'h00, v});
      chk("mask", {7'h00, cpu_rsp.mask}, 8'h01);
    end
  endtask : cmd
  task automatic raise(input int k);
    @(posedge clk_sys);
    case (k)
      0: irq_go <= 1'b1;
      1: timer_count <= TIMER_COUNT_ONE;
      5: serial_flag <= 1'b1;
      6: kbd_flag <= 1'b1;
      default: t16_event <= T16_SRC'(1) << (k - 2);
    endcase
    @(posedge clk_sys);
    irq_go <= 1'b0;
    t16_event <= '0;
    timer_count <= TIMER_COUNT_ZERO;
    cyc(8);
  endtask : raise
  task automatic clear(input int k);
    @(posedge clk_sys);
    case (k)
      0: ;
      1: begin
        rd(ADDR_TCTRL8, 8'h80, "t8_flag");
        wr(ADDR_TCTRL8, 8'h00);
        rd(ADDR_TCTRL8, 8'h00, "t8_clear");
      end
      5: serial_flag <= 1'b0;
      6: kbd_flag <= 1'b0;
      default: begin
        rd(ADDR_TSTAT16, 8'(8'h20 << (k - 2)), "t16_flag");
        rd(ADDR_TASSOC, 8'h00, "assoc");
        rd(ADDR_TSTAT16, 8'h00, "t16_clear");
      end
    endcase
  endtask : clear
  task automatic wait_core(input logic lvl);
    int n;
    n = 0;
    while (cpu_rsp.core_reset !== lvl && n < 200) begin
      cyc(1);
      n++;
    end
    if (n >= 200) begin
      chk("core_reset_wait", 8'h00, 8'h01);
      test_done();
    end
  endtask : wait_core
  task automatic rst_vals();
    rd(ADDR_TCTRL8, 8'h40, "t8_reset");
    rd(ADDR_TCTRL16, 8'h00, "t16_en_reset");
    rd(ADDR_TSTAT16, 8'h00, "t16_flag_reset");
    rd(ADDR_MISC_EN, 8'h00, "misc_reset");
    rd(ADDR_CORE_STAT, 8'h03, "stat_reset");
  endtask : rst_vals
  task automatic test_done();
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    rst_go <= 1'b0;
    cyc(30);
    chk("pin_extends", {7'h00, cpu_rsp.core_reset}, 8'h01);
    wait_core(1'b0);
    rst_vals();
    wr(3'h7, 8'hff);
    rd(3'h6, 8'h00, "unmapped");
    wr(ADDR_TCTRL8, 8'h00);
    wr(ADDR_TCTRL16, 8'he0);
    wr(ADDR_MISC_EN, 8'h03);
    foreach (rows[i]) begin
      raise(rows[i].k);
      cmd(C_MW0, 1'b0, VEC_RESET);
      cmd(C_BND, 1'b1, rows[i].v);
      clear(rows[i].k);
    end
    raise(0);
    raise(1);
    cmd(C_MW0, 1'b0, VEC_RESET);
    cmd(C_BND, 1'b1, VEC_EXT);
    cmd(C_MW0, 1'b0, VEC_RESET);
    cmd(C_BND, 1'b1, VEC_TIMER);
    clear(1);
    raise(5);
    cmd(C_BND, 1'b0, VEC_RESET);
    cmd(C_SOFT, 1'b1, VEC_SWI);
    clear(5);
    wr(ADDR_TCTRL16, 8'h00);
    raise(2);
    cmd(C_MW0, 1'b0, VEC_RESET);
    cmd(C_BND, 1'b0, VEC_RESET);
    clear(2);
    cmd(C_WAIT, 1'b0, VEC_RESET);
    raise(1);
    cmd(C_BND, 1'b1, VEC_TIMER_WAIT);
    chk("wait_latch", {7'h00, cpu_rsp.wait_latch}, 8'h00);
    clear(1);
    @(posedge clk_sys);
    irq_hold <= 1'b1;
    cyc(8);
    rd(ADDR_CORE_STAT, 8'h05, "pin_read");
    cmd(C_MW0, 1'b0, VEC_RESET);
    cmd(C_BND, 1'b1, VEC_EXT);
    chk("edge_take", {7'h00, cpu_rsp_e.take}, 8'h01);
    cmd(C_MW0, 1'b0, VEC_RESET);
    cmd(C_BND, 1'b1, VEC_EXT);
    chk("edge_only", {7'h00, cpu_rsp_e.take}, 8'h00);
    @(posedge clk_sys);
    irq_hold <= 1'b0;
    cyc(8);
    cmd(C_STOP, 1'b0, VEC_RESET);
    rd(ADDR_CORE_STAT, 8'h13, "stop_latch");
    wr(ADDR_TCTRL16, 8'he0);
    @(posedge clk_sys);
    rst_go <= 1'b1;
    @(posedge clk_sys);
    rst_go <= 1'b0;
    wait_core(1'b1);
    wait_core(1'b0);
    rst_vals();
    // A second power-up with the pin high: the count alone ends reset.
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    cyc(POR_SIM - 1);
    chk("por_hold", {7'h00, cpu_rsp.core_reset}, 8'h01);
    cyc(1);
    chk("por_end", {7'h00, cpu_rsp.core_reset}, 8'h00);
    test_done();
  end
endmodule : tb
`default_nettype wire
